// ---- sample_queue_ctrl.sv ----
// Purpose: 256-entry sample queue with watermark, marker, purge and system bits
// Assumes: Register port already decoded from the serial link, one byte per access
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ns
module sample_queue_ctrl #(
  parameter bit DUAL_CHANNEL = 1'b1
) (
  input wire logic clk, // Clock, 125 MHz
  input wire logic rst, // Synchronous reset, high
  input wire sample_queue_pkg::reg_req_s req, // Register access strobes
  output logic [7:0] reg_rdata, // Read data, one cycle after rd
  input wire sample_queue_pkg::sample_s sample_in, // New sample
  output logic sample_ready, // Staging FIFO can take a sample
  input wire logic frame_done, // Frame finished pulse
  input wire logic interface_select_pin, // Pin, asynchronous
  input wire logic frame_sync_pin, // Trigger pin, asynchronous
  output logic i2c_enable, // Two-wire interface active
  output logic spi_enable, // SPI interface active
  output logic use_internal_timing, // Internal oscillator and divider
  output logic frame_sync_out, // Trigger as frame sync
  output logic frame_clk_out, // Trigger as frame-rate clock
  output logic [1:0] channel_power, // Readout channel enables
  output logic osc_enable, // Oscillator running
  output logic frame_restart, // Start new frame pulse
  output logic conv_abort, // Abort conversion pulse
  output logic a_full, // Almost-full flag
  output logic frame_rdy, // Frame-done flag
  output logic data_rdy // Sample-ready flag
);
  import sample_queue_pkg::*;

  // ==========================================================
  // Soft reset sequence and internal clear
  reset_seq_e seq_reg;
  logic clr;
  logic wr_sys;
  logic wr_qc;
  logic wr_rs;
  assign clr = rst || (seq_reg == ST_SOFT_RESET);
  assign wr_sys = req.wr && (req.addr == OFS_SYS_CTRL);
  assign wr_qc = req.wr && (req.addr == OFS_QUEUE_CTRL);
  assign wr_rs = req.wr && (req.addr == OFS_RESTART);

  always_ff @(posedge clk) begin
    if (rst) begin
      seq_reg <= ST_RUN;
    end else begin
      case (seq_reg)
        ST_RUN: begin
          if (wr_sys && req.wdata[BIT_SOFT_RESET]) begin
            seq_reg <= ST_SOFT_RESET;
          end
        end
        ST_SOFT_RESET: begin
          seq_reg <= ST_RUN;
        end
        default: begin
          seq_reg <= ST_RUN;
        end
      endcase
    end
  end

  // ==========================================================
  // Configuration registers
  logic [7:0] wm_reg;
  logic stat_clr_reg;
  logic af_type_reg;
  logic ovw_reg;
  logic two_wire_off_reg;
  logic [1:0] sync_mode_reg;
  logic ch2_sleep_reg;
  logic ch1_sleep_reg;
  logic shutdown_request_reg;

  always_ff @(posedge clk) begin
    if (clr) begin
      wm_reg <= RST_WATERMARK;
      stat_clr_reg <= RST_STAT_CLR;
      af_type_reg <= 1'b0;
      ovw_reg <= 1'b0;
    end else if (req.wr && (req.addr == OFS_WATERMARK)) begin
      wm_reg <= req.wdata;
    end else if (wr_qc) begin
      stat_clr_reg <= req.wdata[BIT_STAT_CLR];
      af_type_reg <= req.wdata[BIT_AF_TYPE];
      ovw_reg <= req.wdata[BIT_OVERWRITE];
    end
  end

  // Shutdown only gates activity; registers stay writable throughout
  always_ff @(posedge clk) begin
    if (clr) begin
      two_wire_off_reg <= 1'b0;
      sync_mode_reg <= SYNC_INTERNAL;
      ch2_sleep_reg <= 1'b0;
      ch1_sleep_reg <= 1'b0;
      shutdown_request_reg <= 1'b0;
    end else if (wr_sys) begin
      two_wire_off_reg <= req.wdata[BIT_TWO_WIRE_OFF];
      sync_mode_reg <= req.wdata[BIT_SYNC_HI:BIT_SYNC_LO];
      ch2_sleep_reg <= req.wdata[BIT_CH2_SLEEP];
      ch1_sleep_reg <= req.wdata[BIT_CH1_SLEEP];
      shutdown_request_reg <= req.wdata[BIT_SHUTDOWN];
    end
  end

  // ==========================================================
  // Pin synchronisers
  logic [1:0] sel_sync_reg;
  logic [1:0] frame_sync_pin_sync_reg;
  always_ff @(posedge clk) begin
    if (rst) begin
      sel_sync_reg <= 2'h0;
      frame_sync_pin_sync_reg <= 2'h0;
    end else begin
      sel_sync_reg <= {sel_sync_reg[0], interface_select_pin};
      frame_sync_pin_sync_reg <= {frame_sync_pin_sync_reg[0], frame_sync_pin};
    end
  end

  // ==========================================================
  // System control outputs
  always_ff @(posedge clk) begin
    if (clr) begin
      i2c_enable <= 1'b0;
      spi_enable <= 1'b0;
      use_internal_timing <= 1'b1;
      frame_sync_out <= 1'b0;
      frame_clk_out <= 1'b0;
      channel_power <= 2'h0;
      osc_enable <= 1'b0;
      frame_restart <= 1'b0;
      conv_abort <= 1'b0;
    end else begin
      i2c_enable <= !two_wire_off_reg && sel_sync_reg[1];
      spi_enable <= two_wire_off_reg || !sel_sync_reg[1];
      use_internal_timing <= (sync_mode_reg == SYNC_INTERNAL) ||
                             (sync_mode_reg == SYNC_INTERNAL_ALT);
      frame_sync_out <= (sync_mode_reg == SYNC_FRAME_SYNC_PIN_FRAME) &&
                        frame_sync_pin_sync_reg[1];
      frame_clk_out <= (sync_mode_reg == SYNC_FRAME_SYNC_PIN_CLOCK) &&
                       frame_sync_pin_sync_reg[1];
      // The single-channel part keeps its one channel on regardless
      channel_power <= DUAL_CHANNEL ?
                       {!ch2_sleep_reg, !ch1_sleep_reg} : 2'h1;
      osc_enable <= !shutdown_request_reg;
      frame_restart <= wr_rs && req.wdata[BIT_RESTART];
      conv_abort <= (wr_rs && req.wdata[BIT_RESTART]) ||
                    (wr_sys && req.wdata[BIT_SHUTDOWN] && !shutdown_request_reg);
    end
  end

  // ==========================================================
  // Staging FIFO
  logic st_valid;
  logic st_ready;
  logic [SAMPLE_W-1:0] st_data;
  logic marker_pend_reg;
  logic purge_now;
  assign purge_now = wr_qc && req.wdata[BIT_PURGE];
  // Marker takes the write slot; shutdown holds samples in the staging FIFO
  assign st_ready = !marker_pend_reg && !shutdown_request_reg && !purge_now;

  stage_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(STAGE_DEPTH)
  ) u_stage (
    .clk(clk),
    .rst(clr || purge_now),
    .in_valid(sample_in.valid),
    .in_ready(sample_ready),
    .in_data(sample_in.data),
    .out_valid(st_valid),
    .out_ready(st_ready),
    .out_data(st_data)
  );

  always_ff @(posedge clk) begin
    if (clr || purge_now) begin
      marker_pend_reg <= 1'b0;
    end else if (wr_qc && req.wdata[BIT_MARKER]) begin
      marker_pend_reg <= 1'b1;
    end else begin
      marker_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Circular queue
  logic [SAMPLE_W-1:0] qmem [QUEUE_DEPTH];
  logic [7:0] wr_idx_reg;
  logic [7:0] rd_idx_reg;
  logic [8:0] count_reg;
  logic [6:0] lost_reg;
  logic [1:0] byte_sel_reg;
  logic push;
  logic [SAMPLE_W-1:0] push_word;
  logic data_rd;
  logic pop;
  logic full;
  logic accept;
  logic over;
  logic drop;
  logic [8:0] count_next;

  assign push = marker_pend_reg || (st_valid && st_ready);
  assign push_word = marker_pend_reg ? MARKER_WORD : st_data;
  assign data_rd = req.rd && (req.addr == OFS_DATA);
  assign pop = data_rd && (byte_sel_reg == LAST_BYTE) &&
               (count_reg != 9'h000);
  assign full = (count_reg == QUEUE_FULL);
  assign accept = push && (!full || pop);
  assign over = push && full && !pop && ovw_reg;
  assign drop = push && full && !pop && !ovw_reg;
  assign count_next = count_reg + {8'h00, accept} - {8'h00, pop};

  always_ff @(posedge clk) begin
    if (accept || over) begin
      qmem[wr_idx_reg] <= push_word;
    end
  end

  always_ff @(posedge clk) begin
    if (clr || purge_now) begin
      wr_idx_reg <= 8'h00;
      rd_idx_reg <= 8'h00;
      count_reg <= 9'h000;
    end else begin
      if (accept || over) begin
        wr_idx_reg <= wr_idx_reg + 8'h01;
      end
      if (pop || over) begin
        rd_idx_reg <= rd_idx_reg + 8'h01;
      end
      count_reg <= count_next;
    end
  end

  always_ff @(posedge clk) begin
    if (clr || purge_now) begin
      lost_reg <= 7'h00;
    end else if (pop) begin
      lost_reg <= 7'h00;
    end else if ((over || drop) && (lost_reg != LOST_MAX)) begin
      lost_reg <= lost_reg + 7'h01;
    end
  end

  // Byte pointer within a sample; address never steps
  always_ff @(posedge clk) begin
    if (clr || purge_now) begin
      byte_sel_reg <= 2'h0;
    end else if (data_rd) begin
      byte_sel_reg <= (byte_sel_reg == LAST_BYTE) ? 2'h0 :
                      byte_sel_reg + 2'h1;
    end
  end

  // ==========================================================
  // Status flags
  logic af_armed_reg;
  logic flag_clr;
  logic af_set;
  logic [8:0] af_level;
  assign af_level = QUEUE_FULL - {1'b0, wm_reg};
  assign flag_clr = (req.rd && (req.addr == OFS_STATUS1)) ||
                    (data_rd && stat_clr_reg);
  assign af_set = (accept || over) && (count_next >= af_level) &&
                  (!af_type_reg || af_armed_reg);

  // Set wins over a read clear; shutdown clears unconditionally
  always_ff @(posedge clk) begin
    if (clr || shutdown_request_reg) begin
      a_full <= 1'b0;
      frame_rdy <= 1'b0;
      data_rdy <= 1'b0;
    end else begin
      a_full <= af_set || (a_full && !flag_clr);
      frame_rdy <= frame_done || (frame_rdy && !flag_clr);
      data_rdy <= (accept || over) || (data_rdy && !flag_clr);
    end
  end

  always_ff @(posedge clk) begin
    if (clr || purge_now) begin
      af_armed_reg <= 1'b1;
    end else if (pop) begin
      af_armed_reg <= 1'b1;
    // A status clear disarms too, so only a later pop, a purge or a reset can re-arm it
    end else if (af_set || (flag_clr && a_full)) begin
      af_armed_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Read data
  logic [SAMPLE_W-1:0] head;
  logic [7:0] rd_byte;
  assign head = qmem[rd_idx_reg];

  always_comb begin
    rd_byte = 8'h00;
    if (req.addr == OFS_STATUS1) begin
      rd_byte = {a_full, frame_rdy, data_rdy, 5'h00};
    end else if (req.addr == OFS_WR_IDX) begin
      rd_byte = wr_idx_reg;
    end else if (req.addr == OFS_RD_IDX) begin
      rd_byte = rd_idx_reg;
    end else if (req.addr == OFS_COUNT1) begin
      rd_byte = {count_reg[8], lost_reg};
    end else if (req.addr == OFS_COUNT2) begin
      rd_byte = count_reg[7:0];
    end else if (req.addr == OFS_DATA) begin
      if (count_reg == 9'h000) begin
        rd_byte = RST_DATA_BYTE;
      end else if (byte_sel_reg == 2'h0) begin
        rd_byte = head[23:16];
      end else if (byte_sel_reg == 2'h1) begin
        rd_byte = head[15:8];
      end else begin
        rd_byte = head[7:0];
      end
    end else if (req.addr == OFS_WATERMARK) begin
      rd_byte = wm_reg;
    end else if (req.addr == OFS_QUEUE_CTRL) begin
      rd_byte = {4'h0, stat_clr_reg, af_type_reg, ovw_reg, 1'b0};
    end else if (req.addr == OFS_RESTART) begin
      rd_byte = 8'h00;
    end else if (req.addr == OFS_SYS_CTRL) begin
      rd_byte = {two_wire_off_reg, 1'b0, sync_mode_reg, ch2_sleep_reg,
                 ch1_sleep_reg, shutdown_request_reg, 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (clr) begin
      reg_rdata <= 8'h00;
    end else if (req.rd) begin
      reg_rdata <= rd_byte;
    end
  end

  // ==========================================================
  // Checks
  a_af_level: assert property (@(posedge clk) disable iff (clr)
    $rose(a_full) && $stable(wm_reg) |->
    count_reg >= QUEUE_FULL - {1'b0, wm_reg})
    else $error("almost-full set below watermark");
  a_marker_push: assert property (@(posedge clk) disable iff (rst)
    (wr_qc && req.wdata[BIT_MARKER] && !purge_now && seq_reg == ST_RUN)
    |=> push && push_word == MARKER_WORD)
    else $error("marker not pushed");
  a_purge_zero: assert property (@(posedge clk) disable iff (rst)
    purge_now |=> count_reg == 9'h000 && wr_idx_reg == 8'h00 &&
    lost_reg == 7'h00)
    else $error("purge left state");
  a_flag_clear: assert property (@(posedge clk) disable iff (clr)
    (data_rd && !stat_clr_reg && !(req.addr == OFS_STATUS1) && a_full &&
    !shutdown_request_reg) |=> a_full)
    else $error("data read cleared flag");
  a_af_hold: assert property (@(posedge clk) disable iff (clr)
    (af_type_reg && !af_armed_reg && !pop && !purge_now) |=>
    !af_armed_reg)
    else $error("rearmed without read");
  a_overwrite: assert property (@(posedge clk) disable iff (clr)
    over && !purge_now |=> rd_idx_reg == $past(rd_idx_reg) + 8'h01 &&
    count_reg == QUEUE_FULL)
    else $error("overwrite indexes");
  a_stop_full: assert property (@(posedge clk) disable iff (clr)
    drop && !purge_now |=> $stable(wr_idx_reg) && $stable(rd_idx_reg))
    else $error("index moved on drop");
  a_restart: assert property (@(posedge clk) disable iff (clr)
    (wr_rs && req.wdata[BIT_RESTART]) |=> frame_restart && conv_abort)
    else $error("restart not issued");
  a_shutdown_request_flags: assert property (@(posedge clk) disable iff (clr)
    shutdown_request_reg |=> !a_full && !frame_rdy && !data_rdy && !osc_enable)
    else $error("shutdown left flags");
  a_lost_sat: assert property (@(posedge clk) disable iff (clr)
    (lost_reg == LOST_MAX && !pop && !purge_now) |=> lost_reg == LOST_MAX)
    else $error("lost tally wrapped");
  a_soft_reset: assert property (@(posedge clk) disable iff (rst)
    (seq_reg == ST_SOFT_RESET) |=> seq_reg == ST_RUN && wm_reg == RST_WATERMARK)
    else $error("soft reset stuck");
endmodule

// ---- sample_queue_pkg.sv ----
// Purpose: Shared constants and carriers for the sample queue and system control
// Assumes: Byte-wide register port, 24-bit samples, one clock domain
// Notes: Offsets are the printed register addresses
package sample_queue_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFS_STATUS1 = 8'h00;
  localparam logic [7:0] OFS_WR_IDX = 8'h03;
  localparam logic [7:0] OFS_RD_IDX = 8'h04;
  localparam logic [7:0] OFS_COUNT1 = 8'h05;
  localparam logic [7:0] OFS_COUNT2 = 8'h06;
  localparam logic [7:0] OFS_DATA = 8'h07;
  localparam logic [7:0] OFS_WATERMARK = 8'h08;
  localparam logic [7:0] OFS_QUEUE_CTRL = 8'h09;
  localparam logic [7:0] OFS_RESTART = 8'h10;
  localparam logic [7:0] OFS_SYS_CTRL = 8'h11;
  // ==========================================================
  // Field positions
  localparam int BIT_A_FULL = 7;
  localparam int BIT_FRAME_RDY = 6;
  localparam int BIT_DATA_RDY = 5;
  localparam int BIT_MARKER = 5;
  localparam int BIT_PURGE = 4;
  localparam int BIT_STAT_CLR = 3;
  localparam int BIT_AF_TYPE = 2;
  localparam int BIT_OVERWRITE = 1;
  localparam int BIT_RESTART = 6;
  localparam int BIT_TWO_WIRE_OFF = 7;
  localparam int BIT_SYNC_HI = 5;
  localparam int BIT_SYNC_LO = 4;
  localparam int BIT_CH2_SLEEP = 3;
  localparam int BIT_CH1_SLEEP = 2;
  localparam int BIT_SHUTDOWN = 1;
  localparam int BIT_SOFT_RESET = 0;
  // ==========================================================
  // Reset values and sizes
  localparam logic [7:0] RST_WATERMARK = 8'h7f;
  localparam logic RST_STAT_CLR = 1'b1;
  localparam logic [7:0] RST_DATA_BYTE = 8'hff;
  localparam int QUEUE_DEPTH = 256;
  localparam logic [8:0] QUEUE_FULL = 9'h100;
  localparam logic [6:0] LOST_MAX = 7'h7f;
  localparam int STAGE_DEPTH = 32;
  localparam int SAMPLE_W = 24;
  localparam logic [1:0] LAST_BYTE = 2'h2;
  // Marker tag word; the value is arbitrary
  localparam logic [23:0] MARKER_WORD = 24'hfffffe;
  // ==========================================================
  // Frame timing source codes
  localparam logic [1:0] SYNC_INTERNAL = 2'h0;
  localparam logic [1:0] SYNC_FRAME_SYNC_PIN_FRAME = 2'h1;
  localparam logic [1:0] SYNC_FRAME_SYNC_PIN_CLOCK = 2'h2;
  localparam logic [1:0] SYNC_INTERNAL_ALT = 2'h3;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

  typedef struct packed {
    logic valid;
    logic [SAMPLE_W-1:0] data;
  } sample_s;

  typedef enum logic [1:0] {
    ST_RUN = 2'b01,
    ST_SOFT_RESET = 2'b10
  } reset_seq_e;
endpackage

// ---- stage_fifo.sv ----
// Purpose: Staging FIFO between the conversion engine and the sample queue
// Assumes: Single clock, synchronous active-high clear
// Notes: Full and empty come from an extra pointer bit
`timescale 1ns/1ns
module stage_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic clk, // Clock
  input wire logic rst, // Synchronous clear, high
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  input wire logic [WIDTH-1:0] in_data, // Write word
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain accepts
  output logic [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_reg;
  logic [AW:0] rp_reg;
  logic do_wr;
  logic do_rd;

  assign in_ready = !((wp_reg[AW] != rp_reg[AW]) &&
                      (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign out_valid = (wp_reg != rp_reg);
  assign out_data = mem[rp_reg[AW-1:0]];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wp_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (do_wr) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (do_rd) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end
endmodule

// ---- host_model.sv ----
// Purpose: Host side of the byte-wide register port
// Assumes: Strobes launch on the falling edge, one byte per access
// Notes: Released lines carry inverted values so stale data never matches
`timescale 1ns/1ns
module host_model (
  input wire logic clk, // Clock
  output sample_queue_pkg::reg_req_s req, // Access strobes
  input wire logic [7:0] rdata // Read byte
);
  import sample_queue_pkg::*;
  initial req = '0;
  // ==========================================================
  // Access tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    d = rdata;
  endtask
  // SPI host turns the two-wire port off first
  task automatic init;
    wr(OFS_SYS_CTRL, 8'h80);
  endtask
endmodule

// ---- sample_fifo_and_system_control_tb.sv ----
// Purpose: Self-checking bench for the sample queue and system control
// Assumes: Host model owns the register port, bench drives the samples
// Notes: Frame sync pin is driven high for the timing-source test
`timescale 1ns/1ns
`define chk(n, e, a) begin checks++; if ((a) !== (e)) begin \
  fail_count++; $display("Error %s exp %h got %h", n, e, a); end end
module sample_fifo_and_system_control_tb;
  import sample_queue_pkg::*;
  logic clk, rst, frame_done, isel, fsync, x;
  reg_req_s req;
  sample_s sin;
  logic [7:0] rdata;
  logic [1:0] cpow;
  logic [1:0] cpow1;
  logic rdy, i2c_en, spi_en, intl, fso, fco, osc, frs, abt, af, frd, drd;
  int checks = 0, fail_count = 0, cyc = 0, fr_seen = 0, ab_seen = 0, n;
  host_model i_host_model (.clk(clk), .req(req), .rdata(rdata));
  sample_queue_ctrl i_sample_queue_ctrl (.clk(clk), .rst(rst), .req(req),
    .reg_rdata(rdata), .sample_in(sin), .sample_ready(rdy),
    .frame_done(frame_done), .interface_select_pin(isel),
    .frame_sync_pin(fsync), .i2c_enable(i2c_en), .spi_enable(spi_en),
    .use_internal_timing(intl), .frame_sync_out(fso),
    .frame_clk_out(fco), .channel_power(cpow), .osc_enable(osc),
    .frame_restart(frs), .conv_abort(abt), .a_full(af),
    .frame_rdy(frd), .data_rdy(drd));
  // Single-channel variant: only its channel enables are watched
  sample_queue_ctrl #(.DUAL_CHANNEL(1'b0)) i_sample_queue_ctrl_one (
    .clk(clk), .rst(rst), .req(req), .reg_rdata(), .sample_in(sin),
    .sample_ready(), .frame_done(frame_done), .interface_select_pin(isel),
    .frame_sync_pin(fsync), .i2c_enable(), .spi_enable(),
    .use_internal_timing(), .frame_sync_out(), .frame_clk_out(),
    .channel_power(cpow1), .osc_enable(), .frame_restart(),
    .conv_abort(), .a_full(), .frame_rdy(), .data_rdy());
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ==========================================================
  // Pulse catchers and hang guard
  always @(posedge clk) begin
    cyc++;
    if (frs === 1'b1) fr_seen++;
    if (abt === 1'b1) ab_seen++;
    if (cyc == 20000) begin
      fail_count++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    i_host_model.rd(a, d);
    `chk($sformatf("reg %h", a), e, d)
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host_model.wr(a, d);
    repeat (2) @(negedge clk);
  endtask
  // Valid drops while the stage is full so no word is taken twice
  task automatic push(input int k);
    for (int i = 0; i < k; i++) begin
      @(negedge clk);
      while (rdy !== 1'b1) begin
        sin.valid = 1'b0;
        @(negedge clk);
      end
      sin = '{valid: 1'b1, data: 24'h123400 + 24'(i)};
    end
    @(negedge clk);
    sin = '{valid: 1'b0, data: ~sin.data};
    repeat (4) @(negedge clk);
  endtask
  task automatic rd_sample(input logic [7:0] lo);
    rc(OFS_DATA, 8'h12);
    rc(OFS_DATA, 8'h34);
    rc(OFS_DATA, lo);
  endtask
  initial begin
    rst = 1'b1;
    sin = '0;
    frame_done = 1'b0;
    isel = 1'b0;
    fsync = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    rc(OFS_WATERMARK, RST_WATERMARK);
    rc(OFS_QUEUE_CTRL, 8'h08);
    rc(OFS_RESTART, 8'h00);
    rc(OFS_SYS_CTRL, 8'h00);
    rc(8'h20, 8'h00);
    repeat (3) rc(OFS_DATA, RST_DATA_BYTE);
    $display("test reset done");
    i_host_model.init;
    @(negedge clk);
    `chk("spi", 1'b1, spi_en)
    `chk("i2c", 1'b0, i2c_en)
    wr(OFS_SYS_CTRL, 8'h00);
    repeat (4) @(negedge clk);
    x = i2c_en;
    isel = 1'b1;
    repeat (4) @(negedge clk);
    `chk("i2c sel", ~x, i2c_en)
    fsync = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_SYS_CTRL, {2'h0, 2'(c), 4'h0});
      `chk("timing", {c == 0 || c == 3, c == 1, c == 2}, {intl, fso, fco})
    end
    wr(OFS_SYS_CTRL, 8'h80);
    `chk("i2c off", 1'b0, i2c_en)
    wr(OFS_SYS_CTRL, 8'h0c);
    `chk("power", 2'h0, cpow)
    `chk("power one", 2'h1, cpow1)
    wr(OFS_SYS_CTRL, 8'h04);
    `chk("power", 2'h2, cpow)
    $display("test system bits done");
    wr(OFS_WATERMARK, 8'hfd);
    push(2);
    `chk("a_full", 1'b0, af)
    push(1);
    `chk("a_full", 1'b1, af)
    rc(OFS_WR_IDX, 8'h03);
    frame_done = 1'b1;
    @(negedge clk) frame_done = 1'b0;
    @(negedge clk);
    `chk("frame_rdy", 1'b1, frd)
    rc(OFS_STATUS1, 8'he0);
    `chk("a_full", 1'b0, af)
    `chk("frame_rdy", 1'b0, frd)
    push(1);
    `chk("a_full", 1'b1, af)
    rd_sample(8'h00);
    `chk("a_full", 1'b0, af)
    rc(OFS_RD_IDX, 8'h01);
    rc(OFS_COUNT2, 8'h03);
    wr(OFS_QUEUE_CTRL, 8'h00);
    push(1);
    rd_sample(8'h01);
    `chk("a_full", 1'b1, af)
    wr(OFS_QUEUE_CTRL, 8'h04);
    rc(OFS_STATUS1, 8'ha0);
    push(1);
    `chk("a_full", 1'b0, af)
    $display("test flags done");
    wr(OFS_QUEUE_CTRL, 8'h20);
    rc(OFS_QUEUE_CTRL, 8'h00);
    rc(OFS_COUNT2, 8'h05);
    wr(OFS_QUEUE_CTRL, 8'h10);
    rc(OFS_COUNT2, 8'h00);
    rc(OFS_WR_IDX, 8'h00);
    rc(OFS_RD_IDX, 8'h00);
    rc(OFS_QUEUE_CTRL, 8'h00);
    $display("test marker purge done");
    push(258);
    rc(OFS_COUNT1, 8'h82);
    rc(OFS_WR_IDX, 8'h00);
    rc(OFS_RD_IDX, 8'h00);
    rd_sample(8'h00);
    rc(OFS_COUNT1, 8'h00);
    wr(OFS_QUEUE_CTRL, 8'h02);
    push(2);
    rc(OFS_WR_IDX, 8'h02);
    rc(OFS_RD_IDX, 8'h02);
    $display("test full done");
    wr(OFS_QUEUE_CTRL, 8'h10);
    wr(OFS_SYS_CTRL, 8'h02);
    `chk("osc", 1'b0, osc)
    `chk("data_rdy", 1'b0, drd)
    n = 0;
    repeat (40) begin
      @(negedge clk);
      sin.valid = (rdy === 1'b1);
      if (rdy === 1'b1) n++;
    end
    sin.valid = 1'b0;
    `chk("staged", STAGE_DEPTH, n)
    rc(OFS_WATERMARK, 8'hfd);
    wr(OFS_SYS_CTRL, 8'h00);
    repeat (50) @(negedge clk);
    rc(OFS_COUNT2, 8'h20);
    `chk("osc", 1'b1, osc)
    $display("test shutdown done");
    wr(OFS_RESTART, 8'h40);
    `chk("restart", 1, fr_seen)
    `chk("abort", 2, ab_seen)
    rc(OFS_RESTART, 8'h00);
    wr(OFS_SYS_CTRL, 8'h01);
    rc(OFS_WATERMARK, RST_WATERMARK);
    rc(OFS_QUEUE_CTRL, 8'h08);
    rc(OFS_SYS_CTRL, 8'h00);
    $display("test restart reset done");
    wrap_up;
  end
endmodule
